// >>> hw/pbc_regs.svh
// offsets, field positions, reset values and timing of the basic control register
// assumes a 50 MHz clock and a byte-addressed 32-bit register bus
`ifndef PBC_REGS_SVH
`define PBC_REGS_SVH

`define PBC_ADDR_W 8
`define PBC_BASIC_CONTROL_ADDR 8'h00

`define PBC_BIT_SOFT_RESET 15
`define PBC_BIT_LOOPBACK 14
`define PBC_BIT_SPEED 13
`define PBC_BIT_ANEG_EN 12
`define PBC_BIT_POWER_DOWN 11
`define PBC_BIT_ISOLATE 10
`define PBC_BIT_RESTART 9
`define PBC_BIT_DUPLEX 8
`define PBC_BIT_COL_TEST 7

`define PBC_RST_LOOPBACK 1'h0
`define PBC_RST_POWER_DOWN 1'h0
`define PBC_RST_RESTART 1'h0
`define PBC_RST_COL_TEST 1'h0
`define PBC_RESERVED_LOW 7'h00

`define PBC_CLK_NS 20
`define PBC_SRST_NS 160
`define PBC_SRST_CYC ((`PBC_SRST_NS + `PBC_CLK_NS - 1) / `PBC_CLK_NS)
`define PBC_CNT_W 4

`endif

// >>> hw/pbc_pkg.sv
// types shared by the basic control register design
// assumes the constants header is included by the modules that need numbers
package pbc_pkg;

	typedef enum logic [0:0] {
		PBC_IDLE = 1'b0,
		PBC_ACK = 1'b1
	} pbc_bus_state_t;

	typedef enum logic [0:0] {
		PBC_SR_IDLE = 1'b0,
		PBC_SR_BUSY = 1'b1
	} pbc_sr_state_t;

endpackage

// >>> hw/pbc_soft_reset.sv
// soft reset sequencer: holds busy for a fixed count, then pulses done
// assumes start is a one-cycle pulse in the clk domain
`timescale 1ns/100ps
`include "pbc_regs.svh"

module pbc_soft_reset (
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	output logic busy,
	output logic done
);

	pbc_pkg::pbc_sr_state_t state;
	pbc_pkg::pbc_sr_state_t next_state;
	logic [`PBC_CNT_W-1:0] count;
	logic [`PBC_CNT_W-1:0] next_count;
	logic next_done;

	always_comb begin
		next_state = state;
		next_count = count;
		next_done = 1'b0;
		case (state)
			pbc_pkg::PBC_SR_IDLE: begin
				if (start) begin
					next_state = pbc_pkg::PBC_SR_BUSY;
					next_count = `PBC_CNT_W'(`PBC_SRST_CYC - 1);
				end
			end
			pbc_pkg::PBC_SR_BUSY: begin
				if (count == `PBC_CNT_W'(0)) begin
					next_state = pbc_pkg::PBC_SR_IDLE;
					next_done = 1'b1;
				end else begin
					next_count = count - `PBC_CNT_W'(1);
				end
			end
			default: begin
				next_state = pbc_pkg::PBC_SR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= pbc_pkg::PBC_SR_IDLE;
			count <= `PBC_CNT_W'(0);
			done <= 1'b0;
		end else begin
			state <= next_state;
			count <= next_count;
			done <= next_done;
		end
	end

	assign busy = (state == pbc_pkg::PBC_SR_BUSY);

endmodule

// >>> hw/pbc_control.sv
// basic control register of a 10/100 transceiver behind an Avalon-MM slave
// assumes synchronous strap pins and a negotiation engine that supplies its result
// How it works
// [RQ1] writing one to bit 15 resets the core; bit clears itself, reads zero after
// [RQ2] speed bit picks 100 or 10 Mb/s, ignored while negotiation is enabled
// [RQ3] negotiation enable runs negotiation; its result overrides speed and duplex bits
// [RQ4] power-down bit powers down; first reset write only clears power-down
// [RQ5] isolate bit cuts the MAC data interface off; zero is normal
// [RQ6] speed, negotiation enable and isolate defaults come from strap pins
// [RQ7] restart bit restarts negotiation and clears itself; resets to zero
// [RQ8] duplex bit picks full when one; default is inverse duplex strap
// [RQ9] loopback bit returns transmit data to receive path; resets to zero
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "pbc_regs.svh"

module pbc_control (
	input wire logic clk,
	input wire logic reset,
	input wire logic [`PBC_ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic strap_speed,
	input wire logic autoneg_strap_pin,
	input wire logic strap_isolate,
	input wire logic strap_duplex,
	input wire logic aneg_speed_100,
	input wire logic aneg_full_duplex,
	output logic phy_soft_reset,
	output logic loopback_en,
	output logic speed_100,
	output logic full_duplex,
	output logic aneg_enable,
	output logic aneg_restart,
	output logic power_down_en,
	output logic isolate_en,
	output logic col_test_en
);

	function automatic logic [15:0] pbc_word(input logic sr, input logic lb, input logic sp,
		input logic an, input logic pd, input logic iso, input logic rs, input logic dp,
		input logic ct);
		pbc_word = {sr, lb, sp, an, pd, iso, rs, dp, ct, `PBC_RESERVED_LOW};
	endfunction

	pbc_pkg::pbc_bus_state_t state;
	pbc_pkg::pbc_bus_state_t next_state;
	logic next_waitrequest;
	logic [31:0] next_readdata;
	logic loopback, speed_sel, aneg_en, power_down, isolate, restart, duplex, col_test;
	logic next_loopback, next_speed_sel, next_aneg_en, next_power_down;
	logic next_isolate, next_restart, next_duplex, next_col_test;
	logic sr_busy, sr_done, sr_start, take, hit;
	logic [15:0] ctrl_word;

	assign hit = (address == `PBC_BASIC_CONTROL_ADDR);
	assign take = (state == pbc_pkg::PBC_ACK) && write && hit;
	assign ctrl_word = pbc_word(sr_busy, loopback, speed_sel, aneg_en, power_down, isolate,
		restart, duplex, col_test);
	// [RQ1] reset write starts core reset
	assign sr_start = take && byteenable[1] && writedata[`PBC_BIT_SOFT_RESET] && !power_down
		&& !sr_busy;

	pbc_soft_reset u_soft_reset (
		.clk(clk),
		.reset(reset),
		.start(sr_start),
		.busy(sr_busy),
		.done(sr_done)
	);

	// bus slave: answer one cycle after the request is seen
	always_comb begin
		next_state = state;
		next_waitrequest = 1'b1;
		next_readdata = readdata;
		case (state)
			pbc_pkg::PBC_IDLE: begin
				if (read || write) begin
					next_state = pbc_pkg::PBC_ACK;
					next_waitrequest = 1'b0;
					if (read) begin
						next_readdata = hit ? {16'h0000, ctrl_word} : 32'h0000_0000;
					end
				end
			end
			pbc_pkg::PBC_ACK: begin
				next_state = pbc_pkg::PBC_IDLE;
			end
			default: begin
				next_state = pbc_pkg::PBC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= pbc_pkg::PBC_IDLE;
			waitrequest <= 1'b1;
			readdata <= 32'h0000_0000;
		end else begin
			state <= next_state;
			waitrequest <= next_waitrequest;
			readdata <= next_readdata;
		end
	end

	// control fields
	always_comb begin
		next_loopback = loopback;
		next_speed_sel = speed_sel;
		next_aneg_en = aneg_en;
		next_power_down = power_down;
		next_isolate = isolate;
		// [RQ7] restart self clear
		next_restart = 1'b0;
		next_duplex = duplex;
		next_col_test = col_test;
		if (sr_done) begin
			// [RQ6] relatch strap defaults
			next_speed_sel = strap_speed;
			next_aneg_en = autoneg_strap_pin;
			next_isolate = strap_isolate;
			// [RQ8] inverse duplex strap
			next_duplex = !strap_duplex;
			// [RQ9] loopback cleared
			next_loopback = `PBC_RST_LOOPBACK;
			next_power_down = `PBC_RST_POWER_DOWN;
			next_col_test = `PBC_RST_COL_TEST;
		end else if (take && !sr_start) begin
			if (byteenable[1]) begin
				next_loopback = writedata[`PBC_BIT_LOOPBACK];
				next_speed_sel = writedata[`PBC_BIT_SPEED];
				next_aneg_en = writedata[`PBC_BIT_ANEG_EN];
				next_power_down = writedata[`PBC_BIT_POWER_DOWN];
				next_isolate = writedata[`PBC_BIT_ISOLATE];
				next_restart = writedata[`PBC_BIT_RESTART];
				next_duplex = writedata[`PBC_BIT_DUPLEX];
				// [RQ4] reset write leaves power-down
				if (writedata[`PBC_BIT_SOFT_RESET] && power_down) begin
					next_power_down = 1'b0;
				end
			end
			if (byteenable[0]) begin
				next_col_test = writedata[`PBC_BIT_COL_TEST];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			loopback <= `PBC_RST_LOOPBACK;
			speed_sel <= strap_speed;
			aneg_en <= autoneg_strap_pin;
			power_down <= `PBC_RST_POWER_DOWN;
			isolate <= strap_isolate;
			restart <= `PBC_RST_RESTART;
			duplex <= !strap_duplex;
			col_test <= `PBC_RST_COL_TEST;
		end else begin
			loopback <= next_loopback;
			speed_sel <= next_speed_sel;
			aneg_en <= next_aneg_en;
			power_down <= next_power_down;
			isolate <= next_isolate;
			restart <= next_restart;
			duplex <= next_duplex;
			col_test <= next_col_test;
		end
	end

	// registered outputs to the transceiver core
	always_ff @(posedge clk) begin
		if (reset) begin
			phy_soft_reset <= 1'b0;
			loopback_en <= 1'b0;
			speed_100 <= 1'b0;
			full_duplex <= 1'b0;
			aneg_enable <= 1'b0;
			aneg_restart <= 1'b0;
			power_down_en <= 1'b0;
			isolate_en <= 1'b0;
			col_test_en <= 1'b0;
		end else begin
			phy_soft_reset <= sr_busy;
			loopback_en <= loopback;
			// [RQ2] manual speed unless negotiating
			speed_100 <= aneg_en ? aneg_speed_100 : speed_sel;
			// [RQ3] negotiated result wins
			full_duplex <= aneg_en ? aneg_full_duplex : duplex;
			aneg_enable <= aneg_en;
			aneg_restart <= restart;
			power_down_en <= power_down;
			// [RQ5] isolate drive
			isolate_en <= isolate;
			col_test_en <= col_test;
		end
	end

	sequence s_req_seen;
		state == pbc_pkg::PBC_IDLE && (read || write);
	endsequence

	sequence s_one_beat_answer;
		!waitrequest ##1 waitrequest;
	endsequence

	property p_bus_answer;
		@(posedge clk) disable iff (reset) s_req_seen |=> s_one_beat_answer;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one beat");

	property p_srst_self_clear;
		@(posedge clk) disable iff (reset) sr_start |=> sr_busy [*8] ##1 !sr_busy; // [RQ1]
	endproperty
	a_srst_self_clear: assert property (p_srst_self_clear) // [RQ1]
		else $error("soft reset length");

	property p_srst_core;
		@(posedge clk) disable iff (reset) sr_start |-> ##2 phy_soft_reset; // [RQ1]
	endproperty
	a_srst_core: assert property (p_srst_core) // [RQ1]
		else $error("core reset not driven");

	property p_manual_speed;
		@(posedge clk) disable iff (reset) !aneg_en |=> speed_100 == $past(speed_sel); // [RQ2]
	endproperty
	a_manual_speed: assert property (p_manual_speed) // [RQ2]
		else $error("manual speed wrong");

	property p_aneg_wins;
		@(posedge clk) disable iff (reset) aneg_en |=> // [RQ3]
			speed_100 == $past(aneg_speed_100) && full_duplex == $past(aneg_full_duplex);
	endproperty
	a_aneg_wins: assert property (p_aneg_wins) // [RQ3]
		else $error("negotiated result ignored");

	property p_pd_exit;
		@(posedge clk) disable iff (reset) // [RQ4]
			take && byteenable[1] && writedata[`PBC_BIT_SOFT_RESET] && power_down
			|=> !power_down && !sr_busy;
	endproperty
	a_pd_exit: assert property (p_pd_exit) // [RQ4]
		else $error("power-down exit wrong");

	property p_isolate;
		@(posedge clk) disable iff (reset) isolate |=> isolate_en; // [RQ5]
	endproperty
	a_isolate: assert property (p_isolate) // [RQ5]
		else $error("isolate not applied");

	property p_strap_load;
		@(posedge clk) disable iff (reset) sr_done |=> // [RQ6]
			aneg_en == $past(autoneg_strap_pin) && speed_sel == $past(strap_speed)
			&& isolate == $past(strap_isolate);
	endproperty
	a_strap_load: assert property (p_strap_load) // [RQ6]
		else $error("strap defaults not loaded");

	property p_restart_pulse;
		@(posedge clk) disable iff (reset) restart |=> !restart && aneg_restart; // [RQ7]
	endproperty
	a_restart_pulse: assert property (p_restart_pulse) // [RQ7]
		else $error("restart not self cleared");

	property p_duplex_strap;
		@(posedge clk) disable iff (reset) sr_done |=> duplex == !$past(strap_duplex); // [RQ8]
	endproperty
	a_duplex_strap: assert property (p_duplex_strap) // [RQ8]
		else $error("duplex default wrong");

	property p_loopback;
		@(posedge clk) disable iff (reset) sr_done |=> !loopback ##1 !loopback_en; // [RQ9]
	endproperty
	a_loopback: assert property (p_loopback) // [RQ9]
		else $error("loopback not cleared");

endmodule

// >>> testbench/pbc_mgmt_master.sv
// management master model: avalon-mm requests to the control register
// assumes one clock and that requests start only after reset is released
`timescale 1ns/100ps
`include "pbc_regs.svh"

module pbc_mgmt_master (
	input wire logic clk,
	output logic [`PBC_ADDR_W-1:0] address,
	output logic read,
	output logic write,
	output logic [31:0] writedata,
	output logic [3:0] byteenable,
	input wire logic [31:0] readdata,
	input wire logic waitrequest
);
	initial begin
		address = '0;
		read = 1'b0;
		write = 1'b0;
		writedata = '0;
		byteenable = 4'h0;
	end

	// one access, held until waitrequest is sampled low
	// no own limit: only the bench watchdog ends a wait that never gets its answer
	task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d,
		input logic [3:0] be, output logic [31:0] q);
		@(posedge clk);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= {~d, d};
		byteenable <= be;
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		// released data lines show garbage, not the old word
		writedata <= {d, ~d};
	endtask
endmodule

// >>> testbench/pbc_control_tb.sv
// self-checking bench for the basic control register
// assumes the master model in pbc_mgmt_master.sv and the design under hw/
`timescale 1ns/100ps
`include "pbc_regs.svh"

module pbc_control_tb;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [`PBC_ADDR_W-1:0] address;
	logic read, write, waitrequest;
	logic [31:0] writedata, readdata, q;
	logic [3:0] byteenable;
	logic [3:0] st = 4'h5;
	logic [1:0] ng = 2'h0;
	logic srst, lb, sp, fd, ae, rs, pd, iso, ct;
	logic [15:0] lf = 16'h0040;
	logic [15:0] sh;
	int error_cnt = 0;
	int n_checks = 0;
	int n_sr = 0;
	int n_rs = 0;
	int s0;

	always #10 clk = ~clk;
	// counts high cycles of the reset and restart outputs
	always @(posedge clk) begin
		n_sr <= n_sr + int'(srst);
		n_rs <= n_rs + int'(rs);
	end

	pbc_control i_pbc_control (.clk(clk), .reset(reset), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .strap_speed(st[3]), .autoneg_strap_pin(st[2]),
		.strap_isolate(st[1]), .strap_duplex(st[0]), .aneg_speed_100(ng[1]),
		.aneg_full_duplex(ng[0]), .phy_soft_reset(srst), .loopback_en(lb), .speed_100(sp),
		.full_duplex(fd), .aneg_enable(ae), .aneg_restart(rs), .power_down_en(pd),
		.isolate_en(iso), .col_test_en(ct));
	pbc_mgmt_master i_pbc_mgmt_master (.clk(clk), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest));

	function logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	// register word loaded from the straps
	function logic [15:0] dflt(input logic [3:0] s);
		return {2'b00, s[3], s[2], 1'b0, s[1], 1'b0, ~s[0], 8'h00};
	endfunction
	// core outputs from a register word and the engine result
	function logic [7:0] outs(input logic [15:0] w, input logic [1:0] g);
		return {w[14], w[12] ? g[1] : w[13], w[12] ? g[0] : w[8], w[12], w[11], w[10], w[7],
			1'b0};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [15:0] d);
		i_pbc_mgmt_master.acc(1'b1, `PBC_BASIC_CONTROL_ADDR, d, 4'hF, q);
	endtask
	task automatic rd_chk(input logic [15:0] exp);
		i_pbc_mgmt_master.acc(1'b0, `PBC_BASIC_CONTROL_ADDR, 16'h0000, 4'hF, q);
		chk(q, {16'h0000, exp});
	endtask
	task automatic out_chk(input logic [15:0] w);
		repeat (2) @(posedge clk);
		chk({24'h0, lb, sp, fd, ae, pd, iso, ct, 1'b0}, {24'h0, outs(w, ng)});
	endtask

	initial begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		rd_chk(dflt(st));
		out_chk(dflt(st));
		$display("reset defaults done");
		for (int i = 0; i < 24; i++) begin
			lf = nxt(lf);
			ng <= lf[1:0];
			sh = lf & 16'h7D80;
			wr(sh | (lf & 16'h007F));
			rd_chk(sh);
			out_chk(sh);
		end
		i_pbc_mgmt_master.acc(1'b1, 8'h04, 16'h4000, 4'hF, q);
		i_pbc_mgmt_master.acc(1'b0, 8'h04, 16'h0000, 4'hF, q);
		chk(q, 32'h0);
		rd_chk(sh);
		// low byte lane only: just the collision test bit moves
		i_pbc_mgmt_master.acc(1'b1, `PBC_BASIC_CONTROL_ADDR, 16'hFFFF, 4'h1, q);
		rd_chk(sh | 16'h0080);
		// high byte lane only: collision test bit kept
		i_pbc_mgmt_master.acc(1'b1, `PBC_BASIC_CONTROL_ADDR, 16'h0000, 4'h2, q);
		rd_chk(16'h0080);
		$display("random fields done");
		s0 = n_rs;
		wr(sh | 16'h0200);
		repeat (4) @(posedge clk);
		chk(32'(n_rs - s0), 32'h1);
		rd_chk(sh);
		$display("restart done");
		st <= 4'(nxt(lf) >> 4);
		wr(16'h4000);
		s0 = n_sr;
		wr(16'hC000);
		rd_chk(16'hC000);
		repeat (12) @(posedge clk);
		chk(32'(n_sr - s0), 32'(`PBC_SRST_CYC));
		rd_chk(dflt(st));
		$display("soft reset done");
		wr(16'h4800);
		s0 = n_sr;
		wr(16'h8100);
		repeat (12) @(posedge clk);
		chk(32'(n_sr - s0), 32'h0);
		rd_chk(16'h0100);
		st <= ~st;
		wr(16'h8000);
		repeat (12) @(posedge clk);
		chk(32'(n_sr - s0), 32'(`PBC_SRST_CYC));
		rd_chk(dflt(st));
		$display("power-down exit done");
		final_report();
	end

	// limit far above the expected run
	initial begin
		#200000;
		error_cnt++;
		final_report();
	end
endmodule
